// >>> rtl/mie_evaluator.sv
// motion impulse evaluator for one function unit of a motion sensor
// assumes all inputs synchronous to core_clk; motion inputs are one-cycle pulses
`default_nettype none
`include "mie_defs.svh"

module mie_evaluator #(
   parameter int          SECTORS         = `MIE_SECTORS,
   // hold lengths in core_clk cycles; a bench may shorten them to reach expiry
   parameter int unsigned STD_HOLD_CYCLES = `MIE_STD_DELAY_MS * `MIE_MS_CYCLES,
   parameter int unsigned EXT_HOLD_CYCLES = `MIE_EXT_HOLD_MS * `MIE_MS_CYCLES
) (
   input  wire logic                 core_clk,
   input  wire logic                 reset_n,
   input  wire logic                 clk_en,
   input  wire mie_pkg::mie_cfg_s    cfg,
   input  wire logic [SECTORS-1:0]   sector_motion,
   input  wire logic [SECTORS-1:0]   sector_assign,
   input  wire logic                 ext_motion,
   input  wire logic                 disable_req,
   input  wire logic                 light_on,
   output var mie_pkg::mie_out_s     out,
   output var mie_pkg::mie_state_e   state
);
   import mie_pkg::*;

   mie_state_e  state_reg, state_next;
   logic [31:0] mon_reg, mon_next;
   logic [31:0] hold_reg, hold_next;
   logic [31:0] rep_reg, rep_next;
   logic [7:0]  cnt_reg, cnt_next;
   logic        beg_reg, beg_next;
   logic        end_reg, end_next;
   logic        tx_reg, tx_next;

   logic        is_det, is_ext, is_lc, is_main, lc_ok, ext_ok, motion, tick_ok;
   logic        beg_gated, end_gated, tx_gated;
   logic [31:0] full_hold;
   logic [7:0]  target;
   logic [SECTORS-1:0] sector_hit;

   // application decoding, shared by the evaluator and the enables
   function automatic logic f_is_det(input mie_cfg_s c);
      f_is_det = (c.app == MIE_APP_DETECTOR);
   endfunction

   // detector forces single role, so an extension setting is ignored there
   function automatic logic f_is_ext(input mie_cfg_s c);
      f_is_ext = (c.app != MIE_APP_DETECTOR) && (c.role == MIE_ROLE_EXT);
   endfunction

   // same reasoning: a detector never acts as a main unit
   function automatic logic f_is_main(input mie_cfg_s c);
      f_is_main = (c.app != MIE_APP_DETECTOR) && (c.role == MIE_ROLE_MAIN);
   endfunction

   // coupled mode is only legal on the first unit in single or main role;
   // an illegal request falls back to plain evaluation rather than half coupling
   function automatic logic f_is_lc(input mie_cfg_s c);
      f_is_lc = (c.app == MIE_APP_LIGHTCTL) && c.first_unit
                && (c.role != MIE_ROLE_EXT);
   endfunction

   // a countdown has lapsed once it holds one or less;
   // zero counts as lapsed too, so a blank load cannot hang a state
   function automatic logic f_lapsed(input logic [31:0] v);
      f_lapsed = (v <= 32'h1);
   endfunction

   // mode flags, decoded once from the static configuration
   assign is_lc   = f_is_lc(cfg);
   assign is_det  = f_is_det(cfg);
   assign is_ext  = f_is_ext(cfg);
   assign is_main = f_is_main(cfg);
   assign ext_ok  = !is_ext;

   // one gate per sector; the or-reduction then merges them into one line
   genvar gi;
   generate
      for (gi = 0; gi < SECTORS; gi = gi + 1) begin : g_sector
         assign sector_hit[gi] = sector_motion[gi] && sector_assign[gi];
      end
   endgenerate

   // external motion only outside extension role
   assign motion = (|sector_hit) || (ext_motion && ext_ok);
   // a zero count would never trigger, so treat it as one
   assign target = (is_det && cfg.impulse_count != 8'h00) ? cfg.impulse_count : 8'h01;
   // a disable request holds the evaluator where it stands
   assign lc_ok   = !disable_req;

   // full delay: extension hold, or standard part plus additional part
   always_comb begin
      if (is_ext) begin
         full_hold = 32'(EXT_HOLD_CYCLES);
      end else begin
         // the sum wraps past 32 bits; add_delay must stay below that headroom
         full_hold = 32'(STD_HOLD_CYCLES) + cfg.add_delay_cycles;
      end
   end
   assign tick_ok = clk_en && lc_ok;

   // next-state logic of the evaluator
   always_comb begin
      state_next = state_reg;
      mon_next   = mon_reg;
      hold_next  = hold_reg;
      rep_next   = rep_reg;
      cnt_next   = cnt_reg;
      beg_next   = 1'b0;
      end_next   = 1'b0;
      tx_next    = 1'b0;
      case (state_reg)
         MIE_ST_IDLE: begin
            if (motion) begin
               if (target == 8'h01) begin
                  state_next = MIE_ST_HOLD;
                  hold_next  = full_hold;
                  beg_next   = cfg.begin_msg_en;
                  tx_next    = is_ext;
                  rep_next   = cfg.repeat_cycles;
               end else begin
                  state_next = MIE_ST_MONITOR;
                  mon_next   = cfg.monitor_cycles;
                  cnt_next   = 8'h01;
               end
            end
         end
         MIE_ST_MONITOR: begin
            if (motion && (cnt_reg + 8'h01 >= target)) begin
               state_next = MIE_ST_HOLD;
               hold_next  = full_hold;
               beg_next   = cfg.begin_msg_en;
               mon_next   = 32'h0;
               cnt_next   = 8'h00;
            end else if (f_lapsed(mon_reg)) begin
               // period lapsed short of the count: drop silently
               state_next = MIE_ST_IDLE;
               cnt_next   = 8'h00;
               mon_next   = 32'h0;
            end else begin
               mon_next = mon_reg - 32'h1;
               if (motion) begin
                  cnt_next = cnt_reg + 8'h01;
               end
            end
         end
         MIE_ST_HOLD: begin
            if (motion) begin
               hold_next = full_hold;
            end else if (f_lapsed(hold_reg)) begin
               state_next = MIE_ST_IDLE;
               hold_next  = 32'h0;
               end_next   = cfg.end_msg_en;
            end else begin
               hold_next = hold_reg - 32'h1;
            end
            // retrigger sends nothing; only the cyclic repeat does
            if (is_ext && state_next == MIE_ST_HOLD) begin
               if (f_lapsed(rep_reg)) begin
                  tx_next  = 1'b1;
                  rep_next = cfg.repeat_cycles;
               end else begin
                  rep_next = rep_reg - 32'h1;
               end
            end
         end
         default: begin
            state_next = MIE_ST_IDLE;
         end
      endcase
   end

   // telegram pulses: a frozen cycle sends nothing, and coupled or extension
   // units never send begin or end messages of their own
   always_comb begin
      beg_gated = 1'b0;
      end_gated = 1'b0;
      tx_gated  = 1'b0;
      if (tick_ok) begin
         beg_gated = beg_next && !is_lc && !is_ext;
         end_gated = end_next && !is_lc && !is_ext;
         tx_gated  = tx_next;
      end
   end

   // evaluator registers; a disable request or a low enable freezes them
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         state_reg <= MIE_ST_IDLE;
         mon_reg   <= 32'h0;
         hold_reg  <= 32'h0;
         rep_reg   <= 32'h0;
         cnt_reg   <= 8'h00;
      end else if (tick_ok) begin
         state_reg <= state_next;
         mon_reg   <= mon_next;
         hold_reg  <= hold_next;
         rep_reg   <= rep_next;
         cnt_reg   <= cnt_next;
      end
   end

   // pulse registers; with clk_en low they hold like all other state,
   // so a pulse may stand longer while the unit is gated
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         beg_reg <= 1'b0;
         end_reg <= 1'b0;
         tx_reg  <= 1'b0;
      end else if (clk_en) begin
         beg_reg <= beg_gated;
         end_reg <= end_gated;
         tx_reg  <= tx_gated;
      end
   end

   // mode-dependent enables
   always_comb begin
      out.begin_msg      = beg_reg;
      out.end_msg        = end_reg;
      out.ext_motion_tx  = tx_reg;
      out.presence       = is_lc && (state_reg == MIE_ST_HOLD);
      out.out1_en        = !is_lc && !is_ext;
      out.out2_en        = !is_lc && !is_ext && !is_det;
      out.twilight_en    = !is_det && !is_lc && !(is_ext && light_on);
      out.teach_en       = !is_det;
      out.coupling_en    = !is_det;
      out.eval_delay_en  = !is_det;
      out.time_ext_en    = !is_det;
      out.actuator_drive = !is_ext && !is_lc;
      out.offbright_eval = !is_ext && !is_det;
      out.twilight_deact = is_main && light_on;
      out.lightctl_disable = is_lc && disable_req;
   end
   assign state = state_reg;
endmodule // mie_evaluator
`default_nettype wire

// >>> pkg/mie_defs.svh
// timing and configuration constants for the motion impulse evaluator
// assumes a 50 MHz core clock; times are given in milliseconds
`ifndef MIE_DEFS_SVH
`define MIE_DEFS_SVH
`define MIE_CLK_HZ              50000000
`define MIE_MS_CYCLES           (`MIE_CLK_HZ / 1000)
`define MIE_REPEAT_MS           9000
`define MIE_EXT_HOLD_MS         6000
`define MIE_STD_DELAY_MS        10000
`define MIE_DEF_IMPULSES        4
`define MIE_DEF_MONITOR_MS      10000
`define MIE_DEF_ADD_DELAY_MS    0
`define MIE_SECTORS             3
`endif

// >>> pkg/mie_pkg.sv
// types shared by the motion impulse evaluator and its bench
// no assumptions beyond a SystemVerilog compiler
`default_nettype none
package mie_pkg;
   typedef enum logic [1:0] {
      MIE_APP_CEILING  = 2'h0,
      MIE_APP_PRESENCE = 2'h1,
      MIE_APP_DETECTOR = 2'h2,
      MIE_APP_LIGHTCTL = 2'h3
   } mie_app_e;

   typedef enum logic [1:0] {
      MIE_ROLE_SINGLE = 2'h0,
      MIE_ROLE_MAIN   = 2'h1,
      MIE_ROLE_EXT    = 2'h2
   } mie_role_e;

   // gray coded along idle -> monitor -> hold
   typedef enum logic [1:0] {
      MIE_ST_IDLE    = 2'h0,
      MIE_ST_MONITOR = 2'h1,
      MIE_ST_HOLD    = 2'h3
   } mie_state_e;

   typedef struct packed {
      mie_app_e  app;
      mie_role_e role;
      logic      first_unit;
      logic      begin_msg_en;
      logic      end_msg_en;
      logic [7:0] impulse_count;
      logic [31:0] monitor_cycles;
      logic [31:0] add_delay_cycles;
      logic [31:0] repeat_cycles;
   } mie_cfg_s;

   typedef struct packed {
      logic begin_msg;
      logic end_msg;
      logic ext_motion_tx;
      logic presence;
      logic out1_en;
      logic out2_en;
      logic twilight_en;
      logic teach_en;
      logic coupling_en;
      logic eval_delay_en;
      logic time_ext_en;
      logic actuator_drive;
      logic offbright_eval;
      logic twilight_deact;
      logic lightctl_disable;
   } mie_out_s;
endpackage : mie_pkg
`default_nettype wire

// >>> bench/mie_sink.sv
// telegram sink standing in for the bus actuators and the main unit
// assumes telegrams are one-cycle pulses on core_clk
`default_nettype none
module mie_sink (
   input  wire logic              core_clk,
   input  wire mie_pkg::mie_out_s out,
   output var int                 n_begin,
   output var int                 n_end,
   output var int                 n_ext
);
   timeunit 1ns;
   timeprecision 1ps;
   initial n_begin = 0;
   initial n_ext = 0;
   initial n_end = 0;
   // all extension telegrams land on one shared group address, so one counter
   always @(posedge core_clk) begin
      if (out.begin_msg === 1'b1) n_begin++;
      if (out.end_msg === 1'b1) n_end++;
      if (out.ext_motion_tx === 1'b1) n_ext++;
   end
endmodule // mie_sink
`default_nettype wire

// >>> bench/mie_evaluator_props.sv
// port-level checker for the motion impulse evaluator
// assumes one clock domain, reset_n synchronous and active low
`default_nettype none
module mie_evaluator_props
   import mie_pkg::*;
(
   input wire logic      core_clk,
   input wire logic      reset_n,
   input wire logic      clk_en,
   input wire mie_cfg_s  cfg,
   input wire logic      disable_req,
   input wire mie_out_s  out,
   input wire mie_state_e state
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   property p_begin_pulse; out.begin_msg && clk_en |=> !out.begin_msg; endproperty
   a_begin_pulse: assert property (p_begin_pulse) else $error("begin pulse too long");
   property p_begin_en; out.begin_msg |-> cfg.begin_msg_en
      && (cfg.app == MIE_APP_DETECTOR || cfg.role != MIE_ROLE_EXT)
      && !(cfg.app == MIE_APP_LIGHTCTL && cfg.first_unit && cfg.role != MIE_ROLE_EXT);
   endproperty
   a_begin_en: assert property (p_begin_en) else $error("begin not enabled");
   property p_begin_hold; out.begin_msg |-> state == MIE_ST_HOLD; endproperty
   a_begin_hold: assert property (p_begin_hold) else $error("begin outside hold");
   property p_end_en; out.end_msg |-> cfg.end_msg_en && state != MIE_ST_HOLD; endproperty
   a_end_en: assert property (p_end_en) else $error("end message misplaced");
   property p_presence; out.presence |-> state == MIE_ST_HOLD; endproperty
   a_presence: assert property (p_presence) else $error("presence without hold");
   // a frozen unit must not move, whatever arrives meanwhile
   property p_freeze; (disable_req || !clk_en) |=> $stable(state); endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");
   property p_det_out; cfg.app == MIE_APP_DETECTOR |-> out.out1_en && !out.out2_en
      && !out.twilight_en && !out.coupling_en; endproperty
   a_det_out: assert property (p_det_out) else $error("detector outputs wrong");
   property p_det_fix; cfg.app == MIE_APP_DETECTOR |-> !out.teach_en && !out.eval_delay_en
      && !out.time_ext_en; endproperty
   a_det_fix: assert property (p_det_fix) else $error("detector presets wrong");
   property p_lc_off; cfg.app == MIE_APP_LIGHTCTL && cfg.first_unit && cfg.role != MIE_ROLE_EXT
      |-> !out.out1_en && !out.out2_en && !out.twilight_en
      && out.lightctl_disable == disable_req; endproperty
   a_lc_off: assert property (p_lc_off) else $error("coupled mode outputs wrong");
   property p_ext_act; cfg.role == MIE_ROLE_EXT && cfg.app != MIE_APP_DETECTOR
      |-> !out.actuator_drive && !out.offbright_eval; endproperty
   a_ext_act: assert property (p_ext_act) else $error("extension drives actuator");
endmodule // mie_evaluator_props
bind mie_evaluator mie_evaluator_props mie_evaluator_props_i (.core_clk(core_clk),
   .reset_n(reset_n), .clk_en(clk_en), .cfg(cfg), .disable_req(disable_req), .out(out),
   .state(state));
`default_nettype wire

// >>> bench/mie_evaluator_tb.sv
// self-checking bench for the motion impulse evaluator
// assumes the sink model and the bound checker; hold times are shortened so the standard hold runs out
`default_nettype none
module mie_evaluator_tb;
   import mie_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic       core_clk = 1'b0;
   logic       reset_n = 1'b0;
   logic       clk_en = 1'b1;
   mie_cfg_s   cfg = '0;
   logic [2:0] sector_motion = 3'h0;
   logic [2:0] sector_assign = 3'h5;
   logic       ext_motion = 1'b0;
   logic       disable_req = 1'b0;
   logic       light_on = 1'b0;
   mie_out_s   out;
   mie_state_e state;
   int         n_begin, n_end, n_ext, b0, d0, e0, e1;
   int         error_cnt = 0;
   int         n_checks = 0;
   int         cyc = 0;
   always #10 core_clk = ~core_clk;
   // holds shortened: 60 cycles standard so that expiry is reached, 1000 extension
   mie_evaluator #(.SECTORS(3), .STD_HOLD_CYCLES(60), .EXT_HOLD_CYCLES(1000))
      mie_evaluator_i (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
      .cfg(cfg), .sector_motion(sector_motion), .sector_assign(sector_assign),
      .ext_motion(ext_motion), .disable_req(disable_req), .light_on(light_on), .out(out),
      .state(state));
   mie_sink mie_sink_i (.core_clk(core_clk), .out(out), .n_begin(n_begin), .n_end(n_end),
      .n_ext(n_ext));
   task print_verdict;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // whole run needs under two thousand cycles
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         print_verdict();
      end
   end
   task chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("Error at %0t: %s", $time, m);
      end
   endtask
   // short monitoring and repeat periods keep the run brief
   task setup(input mie_app_e a, input mie_role_e r);
      @(negedge core_clk);
      reset_n = 1'b0;
      // repeat of 28 cycles stays under half the 60-cycle main hold
      cfg = '{a, r, 1'b1, 1'b1, 1'b1, 8'h04, 32'h000000c8, 32'h0, 32'h0000001c};
      disable_req = 1'b0;
      light_on = 1'b0;
      repeat (2) @(negedge core_clk);
      reset_n = 1'b1;
      b0 = n_begin;
      d0 = n_end;
      e0 = n_ext;
   endtask
   // holding a line n cycles gives n back-to-back impulses
   task pulse(input logic [2:0] s, input logic x, input int n);
      @(negedge core_clk);
      sector_motion = s;
      ext_motion = x;
      repeat (n) @(negedge core_clk);
      sector_motion = 3'h0;
      ext_motion = 1'b0;
   endtask
   initial begin
      repeat (16) @(negedge core_clk);
      setup(MIE_APP_DETECTOR, MIE_ROLE_SINGLE);
      chk(out.out1_en === 1'b1 && out.out2_en === 1'b0, "detector outputs");
      pulse(3'h2, 1'b0, 5);
      chk(state === MIE_ST_IDLE, "unassigned sector counted");
      pulse(3'h1, 1'b0, 3);
      chk(state === MIE_ST_MONITOR, "monitoring not opened");
      repeat (210) @(negedge core_clk);
      chk(state === MIE_ST_IDLE && n_begin == b0, "short burst reported");
      pulse(3'h4, 1'b0, 4);
      repeat (2) @(negedge core_clk);
      chk(state === MIE_ST_HOLD && n_begin == b0 + 1, "no begin at count");
      repeat (50) @(negedge core_clk);
      pulse(3'h1, 1'b0, 1);
      repeat (20) @(negedge core_clk);
      chk(state === MIE_ST_HOLD && n_begin == b0 + 1 && n_end == d0, "retrigger lost");
      repeat (50) @(negedge core_clk);
      chk(state === MIE_ST_IDLE && n_end == d0 + 1, "no end after delay");
      setup(MIE_APP_DETECTOR, MIE_ROLE_SINGLE);
      disable_req = 1'b1;
      pulse(3'h1, 1'b0, 6);
      chk(state === MIE_ST_IDLE && n_begin == b0, "disabled unit reacted");
      disable_req = 1'b0;
      clk_en = 1'b0;
      pulse(3'h1, 1'b0, 6);
      chk(state === MIE_ST_IDLE && n_begin == b0, "gated unit reacted");
      clk_en = 1'b1;
      setup(MIE_APP_CEILING, MIE_ROLE_EXT);
      pulse(3'h0, 1'b1, 3);
      chk(state === MIE_ST_IDLE, "extension took external motion");
      chk(out.actuator_drive === 1'b0, "extension drives actuator");
      pulse(3'h1, 1'b0, 1);
      repeat (350) @(negedge core_clk);
      chk(n_ext - e0 >= 12 && n_ext - e0 <= 14, "repeat telegrams wrong");
      e1 = n_ext;
      pulse(3'h4, 1'b0, 1);
      repeat (3) @(negedge core_clk);
      chk(n_ext == e1, "retrigger sent telegram");
      setup(MIE_APP_LIGHTCTL, MIE_ROLE_MAIN);
      light_on = 1'b1;
      pulse(3'h0, 1'b1, 1);
      @(negedge core_clk);
      chk(out.presence === 1'b1 && out.out1_en === 1'b0, "presence missing");
      chk(out.twilight_deact === 1'b1, "twilight not deactivated");
      disable_req = 1'b1;
      #1;
      chk(out.lightctl_disable === 1'b1, "disable not forwarded");
      print_verdict();
   end
endmodule // mie_evaluator_tb
`default_nettype wire
